// *** verilog/iapfw_cfg.svh ***
// Constants for the in-application flash programming sequencer
// ==========================================================================
// Operation
// - Erase and program act on 32-word pages; reads act on single words.
// - Erase/write enabled flag rises only after a successful unlock.
// - Write buffer accepts data only while erase/write enabled flag is set.
// - Write start set by firmware, held while busy, cleared by hardware.
// - Read needs read enable set; firmware then sets read start.
// - Hardware clears read start when the word read completes.
// - Address splits into page number (high reg, low[7:5]) and offset [4:0].
// - Buffer clear start set by firmware, cleared by hardware when done.
// - Write buffer belongs to the page chosen by the page select bits.
// - Data high write moves the word into the buffer; low write only holds.
// - Each buffer transfer below offset 11111b increments the word address and writes it back.
// - At offset 11111b the address stays on the page's last word.
// - Hardware clears the write buffer after every page program.
// - Mode field: 000 program, 001 erase, 011 read, 110 unlock.
// - Unlock trigger starts a timer and clears on expiry; patterns before.
// - CPU is stalled while a started read, program or erase runs.
`ifndef IAPFW_CFG_SVH
`define IAPFW_CFG_SVH

// ==========================================================================
// Register offsets
`define IAP_A_CTRL     8'h00
`define IAP_A_CTRL2    8'h02
`define IAP_A_ADDRL    8'h03
`define IAP_A_ADDRH    8'h04
`define IAP_A_DATAL    8'h05
`define IAP_A_DATAH    8'h06
`define IAP_A_PAT_LO   8'h07
`define IAP_A_PAT_HI   8'h0c

// ==========================================================================
// Control register fields
`define IAP_B_EWEN     7
`define IAP_B_MODE_HI  6
`define IAP_B_MODE_LO  4
`define IAP_B_UNLK     3
`define IAP_B_WST      2
`define IAP_B_REN      1
`define IAP_B_RST      0
`define IAP_B_TSEL     1
`define IAP_B_CLR      0

// ==========================================================================
// Mode codes and geometry
`define IAP_MODE_PROG  3'h0
`define IAP_MODE_ERASE 3'h1
`define IAP_MODE_READ  3'h3
`define IAP_MODE_UNLK  3'h6
`define IAP_LAST_WORD  5'h1f
`define IAP_CLR_VAL    16'hffff
`define IAP_PAT1       16'h0000
`define IAP_PAT2       16'h0000
`define IAP_PAT3       16'h0000

// ==========================================================================
// Timing, microseconds at a 10 MHz clock
`define IAP_CLK_MHZ    10
`define IAP_T_ER0_US   3200
`define IAP_T_ER1_US   3700
`define IAP_T_WR0_US   2200
`define IAP_T_WR1_US   3000
`define IAP_T_UNLK_US  1000
`define IAP_US_CYC(us) ((us) * `IAP_CLK_MHZ)

`endif

// *** verilog/iapfw_pkg.sv ***
// Types shared by the flash programming sequencer
package iapfw_pkg;
	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE, S_READ, S_RDATA, S_LOAD, S_PROG, S_ERASE
	} iapfw_state_t;
	typedef logic [15:0] iapfw_word_t;
endpackage

// *** verilog/iapfw_wbuf_if.sv ***
// Link between the sequencer and its page write buffer
`timescale 1ns/10ps
interface iapfw_wbuf_if;
	logic                ce;
	logic                wr;
	logic [4:0]          wr_idx;
	iapfw_pkg::iapfw_word_t wr_data;
	logic [4:0]          rd_idx;
	iapfw_pkg::iapfw_word_t rd_data;
	logic                clr_go;
	logic                clr_busy;
	modport owner (input ce, wr, wr_idx, wr_data, rd_idx, clr_go,
		output rd_data, clr_busy);
	modport user (output ce, wr, wr_idx, wr_data, rd_idx, clr_go,
		input rd_data, clr_busy);
endinterface

// *** verilog/iapfw_wbuf.sv ***
// Thirty-two word page write buffer with walking clear
`timescale 1ns/10ps
`include "iapfw_cfg.svh"
module iapfw_wbuf (
	// Clock and reset
	input  wire logic     i_clock,
	input  wire logic     i_nrst,
	// Buffer access
	iapfw_wbuf_if.owner   bus
);
	iapfw_pkg::iapfw_word_t mem [32];
	logic [4:0]             cidx;

	// ======================================================================
	// Clear walker, one entry a cycle
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			bus.clr_busy <= 1'b0;
			cidx         <= 5'h00;
		end else if (bus.ce) begin
			if (!bus.clr_busy && bus.clr_go) begin
				bus.clr_busy <= 1'b1;
				cidx         <= 5'h00;
			end else if (bus.clr_busy) begin
				cidx <= cidx + 5'h01;
				if (cidx == `IAP_LAST_WORD)
					bus.clr_busy <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Storage, no reset: contents are unknown until the first clear
	always_ff @(posedge i_clock) begin
		if (bus.ce) begin
			if (bus.clr_busy)
				mem[cidx] <= `IAP_CLR_VAL; // Clear beats a fill
			else if (bus.wr)
				mem[bus.wr_idx] <= bus.wr_data;
		end
	end

	// Read port for the program stream
	assign bus.rd_data = mem[bus.rd_idx];

	a_clear_length: assert property (@(posedge i_clock) disable iff (!i_nrst)
		$rose(bus.clr_busy) |-> ##[32:300] !bus.clr_busy)
		else $error("buffer clear did not finish");
endmodule // iapfw_wbuf

// *** verilog/iapfw_top.sv ***
// In-application flash programming sequencer with page write buffer
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "iapfw_cfg.svh"
module iapfw_top #(
	parameter int unsigned ER0_CYC  = `IAP_US_CYC(`IAP_T_ER0_US),
	parameter int unsigned ER1_CYC  = `IAP_US_CYC(`IAP_T_ER1_US),
	parameter int unsigned WR0_CYC  = `IAP_US_CYC(`IAP_T_WR0_US),
	parameter int unsigned WR1_CYC  = `IAP_US_CYC(`IAP_T_WR1_US),
	parameter int unsigned UNLK_CYC = `IAP_US_CYC(`IAP_T_UNLK_US),
	parameter logic [15:0] PAT1     = `IAP_PAT1,
	parameter logic [15:0] PAT2     = `IAP_PAT2,
	parameter logic [15:0] PAT3     = `IAP_PAT3
) (
	// Clock, reset, enable
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	input  wire logic        i_clk_en,
	// Register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// Flash array port
	output logic      [11:0] o_fl_addr,
	output logic      [15:0] o_fl_wdata,
	output logic             o_fl_wr,
	output logic             o_fl_erase,
	output logic             o_fl_rd,
	input  wire logic [15:0] i_fl_rdata,
	// CPU hold
	output logic             o_cpu_stall
);
	iapfw_pkg::iapfw_state_t state;
	logic        erase_write_enabled_flag;
	logic [2:0]  op_mode_select;
	logic        unlock_trigger;
	logic        write_start;
	logic        read_enable_bit;
	logic        read_start;
	logic        erase_time_sel;
	logic [7:0]  addr_low_reg;
	logic [3:0]  addr_high_reg;
	logic [7:0]  data_low_reg;
	logic [7:0]  data_high_reg;
	logic [7:0]  pat [6];
	logic [15:0] unlock_timer;
	logic [15:0] cnt;
	logic [4:0]  widx;
	logic [7:0]  rd_mux;
	logic        wr_ctrl;
	logic        wr_datah;
	logic        new_wst;
	logic [2:0]  new_mode;
	logic        start_prog;
	logic        start_erase;
	logic        start_read;
	logic        unlock_ok;
	logic        buf_xfer;
	logic        prog_done;
	logic        clr_sw;

	iapfw_wbuf_if wb ();

	iapfw_wbuf u_wbuf (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.bus     (wb)
	);

	// ======================================================================
	// Decode of bus writes and operation starts
	assign wr_ctrl   = i_wr && (i_addr == `IAP_A_CTRL);
	assign wr_datah  = i_wr && (i_addr == `IAP_A_DATAH);
	assign new_mode  = i_wdata[`IAP_B_MODE_HI:`IAP_B_MODE_LO];
	assign new_wst   = wr_ctrl && i_wdata[`IAP_B_WST] && !write_start;
	// Program and erase need the enable flag; otherwise the bit stays 0
	assign start_prog  = new_wst && (state == iapfw_pkg::S_IDLE)
		&& erase_write_enabled_flag
		&& (new_mode == `IAP_MODE_PROG);
	assign start_erase = new_wst && (state == iapfw_pkg::S_IDLE)
		&& erase_write_enabled_flag
		&& (new_mode == `IAP_MODE_ERASE);
	assign start_read  = wr_ctrl && i_wdata[`IAP_B_RST] && read_enable_bit
		&& !read_start && (state == iapfw_pkg::S_IDLE)
		&& (new_mode == `IAP_MODE_READ);
	// Last pattern byte completes the unlock inside the timer window
	assign unlock_ok = unlock_trigger && (op_mode_select == `IAP_MODE_UNLK)
		&& i_wr && (i_addr == `IAP_A_PAT_HI)
		&& ({pat[1], pat[0]} == PAT1) && ({pat[3], pat[2]} == PAT2)
		&& ({i_wdata, pat[4]} == PAT3);
	assign buf_xfer = wr_datah && erase_write_enabled_flag
		&& (state == iapfw_pkg::S_IDLE);
	assign prog_done = (state == iapfw_pkg::S_PROG) && (cnt == 16'h0001);
	assign clr_sw = i_wr && (i_addr == `IAP_A_CTRL2)
		&& i_wdata[`IAP_B_CLR];

	// ======================================================================
	// Buffer hookup: fill at the word offset, stream by the load index
	assign wb.ce      = i_clk_en;
	assign wb.wr      = buf_xfer && i_clk_en;
	assign wb.wr_idx  = addr_low_reg[4:0];
	assign wb.wr_data = {i_wdata, data_low_reg};
	assign wb.rd_idx  = widx;
	assign wb.clr_go  = clr_sw || prog_done;

	// ======================================================================
	// Erase/write enable flag: software may only clear; set wins a tie
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			erase_write_enabled_flag <= 1'b0;
		else if (i_clk_en) begin
			if (unlock_ok)
				erase_write_enabled_flag <= 1'b1;
			else if (wr_ctrl && !i_wdata[`IAP_B_EWEN])
				erase_write_enabled_flag <= 1'b0;
		end
	end

	// ======================================================================
	// Mode, read enable and timing select
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			op_mode_select  <= 3'h0;
			read_enable_bit <= 1'b0;
			erase_time_sel  <= 1'b0;
		end else if (i_clk_en) begin
			if (wr_ctrl) begin
				op_mode_select  <= new_mode;
				read_enable_bit <= i_wdata[`IAP_B_REN];
			end
			if (i_wr && (i_addr == `IAP_A_CTRL2))
				erase_time_sel <= i_wdata[`IAP_B_TSEL];
		end
	end

	// ======================================================================
	// Unlock trigger and its window timer
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			unlock_trigger <= 1'b0;
			unlock_timer   <= 16'h0000;
		end else if (i_clk_en) begin
			if (wr_ctrl && i_wdata[`IAP_B_UNLK] && !unlock_trigger) begin
				unlock_trigger <= 1'b1;
				unlock_timer   <= 16'(UNLK_CYC);
			end else if (unlock_trigger) begin
				unlock_timer <= unlock_timer - 16'h0001;
				if (unlock_timer == 16'h0001)
					unlock_trigger <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Unlock pattern bytes, kept readable
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_pat
			always_ff @(posedge i_clock or negedge i_nrst) begin
				if (!i_nrst)
					pat[gi] <= 8'h00;
				else if (i_clk_en && i_wr
					&& (i_addr == `IAP_A_PAT_LO + 8'(gi)))
					pat[gi] <= i_wdata;
			end
		end
	endgenerate

	// ======================================================================
	// Word address with auto increment that stops at the page end
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			addr_low_reg  <= 8'h00;
			addr_high_reg <= 4'h0;
		end else if (i_clk_en) begin
			if (i_wr && (i_addr == `IAP_A_ADDRL))
				addr_low_reg <= i_wdata;
			else if (i_wr && (i_addr == `IAP_A_ADDRH))
				addr_high_reg <= i_wdata[3:0];
			else if (buf_xfer
				&& (addr_low_reg[4:0] != `IAP_LAST_WORD))
				{addr_high_reg, addr_low_reg} <=
					{addr_high_reg, addr_low_reg} + 12'h001;
		end
	end

	// ======================================================================
	// Data holding registers; a read result lands here too
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			data_low_reg  <= 8'h00;
			data_high_reg <= 8'h00;
		end else if (i_clk_en) begin
			if (state == iapfw_pkg::S_RDATA)
				{data_high_reg, data_low_reg} <= i_fl_rdata;
			else if (i_wr && (i_addr == `IAP_A_DATAL))
				data_low_reg <= i_wdata;
			else if (wr_datah)
				data_high_reg <= i_wdata;
		end
	end

	// ======================================================================
	// Start bits: set by the start, dropped by hardware at the end
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			write_start <= 1'b0;
			read_start  <= 1'b0;
		end else if (i_clk_en) begin
			if (start_prog || start_erase)
				write_start <= 1'b1;
			else if (prog_done || ((state == iapfw_pkg::S_ERASE)
				&& (cnt == 16'h0001)))
				write_start <= 1'b0;
			if (start_read)
				read_start <= 1'b1;
			else if (state == iapfw_pkg::S_RDATA)
				read_start <= 1'b0;
		end
	end

	// ======================================================================
	// Operation sequencer
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= iapfw_pkg::S_IDLE;
			cnt   <= 16'h0000;
			widx  <= 5'h00;
		end else if (i_clk_en) begin
			unique case (state)
				iapfw_pkg::S_IDLE: begin
					widx <= 5'h00;
					if (start_read)
						state <= iapfw_pkg::S_READ;
					else if (start_prog)
						state <= iapfw_pkg::S_LOAD;
					else if (start_erase) begin
						state <= iapfw_pkg::S_ERASE;
						cnt   <= erase_time_sel ? 16'(ER1_CYC)
							: 16'(ER0_CYC);
					end
				end
				iapfw_pkg::S_READ:
					state <= iapfw_pkg::S_RDATA;
				iapfw_pkg::S_RDATA:
					state <= iapfw_pkg::S_IDLE;
				iapfw_pkg::S_LOAD: begin
					widx <= widx + 5'h01;
					if (widx == `IAP_LAST_WORD) begin
						state <= iapfw_pkg::S_PROG;
						cnt   <= erase_time_sel ? 16'(WR1_CYC)
							: 16'(WR0_CYC);
					end
				end
				iapfw_pkg::S_PROG, iapfw_pkg::S_ERASE: begin
					cnt <= cnt - 16'h0001;
					if (cnt == 16'h0001)
						state <= iapfw_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ======================================================================
	// Flash strobes, from flops so the array sees clean levels
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_fl_addr  <= 12'h000;
			o_fl_wdata <= 16'h0000;
			o_fl_wr    <= 1'b0;
			o_fl_erase <= 1'b0;
			o_fl_rd    <= 1'b0;
		end else if (i_clk_en) begin
			o_fl_rd    <= start_read;
			o_fl_erase <= start_erase;
			o_fl_wr    <= (state == iapfw_pkg::S_LOAD);
			if (start_read || start_erase)
				o_fl_addr <= {addr_high_reg, addr_low_reg};
			else if (state == iapfw_pkg::S_LOAD) begin
				o_fl_addr  <= {addr_high_reg, addr_low_reg[7:5], widx};
				o_fl_wdata <= wb.rd_data;
			end
		end
	end

	// Hold the CPU while any operation is under way
	assign o_cpu_stall = (state != iapfw_pkg::S_IDLE);

	// ======================================================================
	// Register readback; unused offsets read zero
	always_comb begin
		rd_mux = 8'h00;
		unique case (i_addr)
			`IAP_A_CTRL:  rd_mux = {erase_write_enabled_flag, op_mode_select,
				unlock_trigger, write_start, read_enable_bit, read_start};
			`IAP_A_CTRL2: rd_mux = {6'h00, erase_time_sel, wb.clr_busy};
			`IAP_A_ADDRL: rd_mux = addr_low_reg;
			`IAP_A_ADDRH: rd_mux = {4'h0, addr_high_reg};
			`IAP_A_DATAL: rd_mux = data_low_reg;
			`IAP_A_DATAH: rd_mux = data_high_reg;
			default: begin
				if ((i_addr >= `IAP_A_PAT_LO) && (i_addr <= `IAP_A_PAT_HI))
					rd_mux = pat[3'(i_addr - `IAP_A_PAT_LO)];
			end
		endcase
	end

	// Read data stand in the cycle after the strobe only
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst)
			o_rdata <= 8'h00;
		else if (i_clk_en)
			o_rdata <= i_rd ? rd_mux : 8'h00;
	end

	// ======================================================================
	// Checks
	a_unlock_cause: assert property (@(posedge i_clock) disable iff (!i_nrst)
		$rose(erase_write_enabled_flag) |-> $past(unlock_ok))
		else $error("enable flag rose without unlock");
	a_fill_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
		wb.wr |-> erase_write_enabled_flag)
		else $error("buffer filled while locked");
	a_low_holds: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_wr && (i_addr == `IAP_A_DATAL)) |-> !wb.wr)
		else $error("low byte write reached buffer");
	a_addr_step: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(wb.wr && (addr_low_reg[4:0] != `IAP_LAST_WORD)) |=>
		({addr_high_reg, addr_low_reg}
		== $past({addr_high_reg, addr_low_reg}) + 12'h001))
		else $error("address did not step");
	a_addr_stop: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(wb.wr && (addr_low_reg[4:0] == `IAP_LAST_WORD)) |=>
		$stable(addr_low_reg) && $stable(addr_high_reg))
		else $error("address left the page");
	a_write_end: assert property (@(posedge i_clock) disable iff (!i_nrst)
		$fell(write_start) |-> $past(state == iapfw_pkg::S_PROG
		|| state == iapfw_pkg::S_ERASE))
		else $error("write start dropped early");
	a_read_end: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_clk_en && state == iapfw_pkg::S_RDATA) |=> !read_start)
		else $error("read start not cleared");
	a_auto_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_clk_en && prog_done) |=> wb.clr_busy)
		else $error("buffer not cleared after program");
	a_stall_busy: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(o_fl_wr || o_fl_erase || o_fl_rd) |-> o_cpu_stall)
		else $error("cpu not stalled");
	a_erase_mode: assert property (@(posedge i_clock) disable iff (!i_nrst)
		o_fl_erase |-> (op_mode_select == `IAP_MODE_ERASE)
		&& $past(erase_write_enabled_flag))
		else $error("erase outside erase mode");
endmodule // iapfw_top

// *** sim/iapfw_tb.sv ***
// Self-checking testbench for the flash programming sequencer
`timescale 1ns/10ps
// ==========================================================================
// Bench top
module tb;
	logic        i_clock;
	logic        i_nrst;
	logic        i_clk_en;
	logic [7:0]  i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic [11:0] o_fl_addr;
	logic [15:0] o_fl_wdata;
	logic        o_fl_wr;
	logic        o_fl_erase;
	logic        o_fl_rd;
	logic [15:0] i_fl_rdata;
	logic        o_cpu_stall;
	int          miscompares;
	int          num_checks;
	int          nwr;
	int          ners;
	int          nrd;
	logic [11:0] wa [0:127];
	logic [15:0] wd [0:127];
	logic [11:0] ea;

	// Short timings keep the run small; unlock window fits six writes
	// Time select stays 0, so the long timings and third pattern default
	iapfw_top #(.ER0_CYC(20), .WR0_CYC(20), .UNLK_CYC(40),
		.PAT1(16'h5a01), .PAT2(16'h5a02)) dut_u (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_fl_addr(o_fl_addr),
		.o_fl_wdata(o_fl_wdata), .o_fl_wr(o_fl_wr),
		.o_fl_erase(o_fl_erase), .o_fl_rd(o_fl_rd),
		.i_fl_rdata(i_fl_rdata), .o_cpu_stall(o_cpu_stall));

	// 10 MHz clock
	always #50 i_clock = ~i_clock;

	// Flash side monitor; outputs are registered so edge sampling is safe
	always @(posedge i_clock) begin
		if (o_fl_wr === 1'b1) begin
			wa[nwr] <= o_fl_addr;
			wd[nwr] <= o_fl_wdata;
			nwr <= nwr + 1;
		end
		if (o_fl_erase === 1'b1) begin
			ners <= ners + 1;
			ea <= o_fl_addr;
		end
		if (o_fl_rd === 1'b1)
			nrd <= nrd + 1;
	end

	// ======================================================================
	// Shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Returns at the taking edge so the next cycle can be sampled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check({8'h00, d}, {8'h00, exp});
	endtask

	task automatic wait_idle(input int n);
		int k;
		k = 0;
		#1;
		while (o_cpu_stall !== 1'b0 && k < n) begin
			@(posedge i_clock);
			#1 k++;
		end
		if (k >= n) begin
			miscompares++;
			test_done;
		end
	endtask

	// Buffer clear busy bit must fall within a bounded number of polls
	task automatic wait_clear;
		int k;
		logic [7:0] d;
		k = 0;
		d = 8'h01;
		while (d[0] !== 1'b0 && k < 50) begin
			rd(8'h02, d);
			k++;
		end
		if (k >= 50) begin
			miscompares++;
			test_done;
		end
	endtask

	task automatic unlock(input logic [15:0] p3);
		wr(8'h00, 8'h68);
		wr(8'h07, 8'h01);
		wr(8'h08, 8'h5a);
		wr(8'h09, 8'h02);
		wr(8'h0a, 8'h5a);
		wr(8'h0b, p3[7:0]);
		wr(8'h0c, p3[15:8]);
	endtask

	// ======================================================================
	// Scenarios
	task automatic scen_reset;
		foreach (wa[k]) if (k < 7) rdchk(8'h00 + k[7:0], 8'h00);
		rdchk(8'h20, 8'h00);
		check({o_fl_wr, o_fl_erase, o_fl_rd, o_cpu_stall}, 16'h0000);
		// Enable low must freeze the registers against a bus write
		@(posedge i_clock);
		i_clk_en <= 1'b0;
		wr(8'h03, 8'h55);
		i_clk_en <= 1'b1;
		rdchk(8'h03, 8'h00);
	endtask

	// Everything that needs the enable flag must do nothing while locked
	task automatic scen_locked;
		wr(8'h03, 8'h00);
		wr(8'h05, 8'h11);
		wr(8'h06, 8'h22);
		rdchk(8'h03, 8'h00);
		wr(8'h00, 8'h04);
		#1 check({15'h0, o_cpu_stall}, 16'h0000);
		wr(8'h00, 8'h14);
		repeat (40) @(posedge i_clock);
		check(nwr[15:0] + ners[15:0], 16'h0000);
		wr(8'h00, 8'h80);
		rdchk(8'h00, 8'h00);
	endtask

	task automatic scen_read;
		wr(8'h03, 8'he5);
		wr(8'h04, 8'h0f);
		i_fl_rdata <= 16'hc3a5;
		wr(8'h00, 8'h31);
		repeat (5) @(posedge i_clock);
		check(nrd[15:0], 16'h0000);
		rdchk(8'h00, 8'h30);
		wr(8'h00, 8'h02);
		wr(8'h00, 8'h33);
		#1 check({o_cpu_stall, o_fl_rd, 2'b00, o_fl_addr}, 16'hcfe5);
		wait_idle(10);
		check(nrd[15:0], 16'h0001);
		rdchk(8'h05, 8'ha5);
		rdchk(8'h06, 8'hc3);
		rdchk(8'h00, 8'h32);
	endtask

	task automatic scen_unlock;
		logic [7:0] d;
		unlock(16'h5a04);
		rd(8'h00, d);
		check({15'h0, d[7]}, 16'h0000);
		repeat (60) @(posedge i_clock);
		rdchk(8'h00, 8'h60);
		unlock(16'h0000);
		rdchk(8'h00, 8'he8);
		repeat (60) @(posedge i_clock);
		rdchk(8'h00, 8'he0);
	endtask

	// Fill page 0x7d from offset 0, then one word past the boundary
	task automatic scen_fill;
		wr(8'h02, 8'h01);
		rdchk(8'h02, 8'h01);
		wait_clear;
		wr(8'h04, 8'h0f);
		wr(8'h03, 8'ha0);
		for (int k = 0; k < 33; k++) begin
			wr(8'h05, k[7:0]);
			if (k == 0) rdchk(8'h03, 8'ha0);
			wr(8'h06, 8'h80 ^ k[7:0]);
			rdchk(8'h03, 8'ha0 | ((k < 31) ? k[7:0] + 8'h01 : 8'h1f));
		end
		rdchk(8'h04, 8'h0f);
	endtask

	task automatic scen_program(input logic fresh);
		int b;
		logic [15:0] exp;
		b = nwr;
		wr(8'h00, 8'h84);
		#1 check({15'h0, o_cpu_stall}, 16'h0001);
		wait_idle(200);
		check(nwr[15:0] - b[15:0], 16'h0020);
		for (int k = 0; k < 32; k++) begin
			exp = (k == 31) ? 16'ha020 : {8'h80 ^ k[7:0], k[7:0]};
			if (!fresh) exp = 16'hffff;
			check({4'h0, wa[b + k]}, {4'h0, 7'h7d, k[4:0]});
			check(wd[b + k], exp);
		end
		rdchk(8'h00, 8'h80);
		wait_clear;
	endtask

	task automatic scen_erase;
		int b;
		b = ners;
		// Fill left the offset pinned at the last word; reload the page
		wr(8'h04, 8'h0f);
		wr(8'h03, 8'ha0);
		wr(8'h00, 8'h94);
		#1 check({15'h0, o_cpu_stall}, 16'h0001);
		wait_idle(200);
		check(ners[15:0] - b[15:0], 16'h0001);
		check({9'h0, ea[11:5]}, 16'h007d);
		rdchk(8'h00, 8'h90);
	endtask

	// Reserved codes start nothing, then a locked erase does nothing
	task automatic scen_reserved;
		int s;
		logic [2:0] codes [4] = '{3'h2, 3'h4, 3'h5, 3'h7};
		s = nwr + ners + nrd;
		foreach (codes[k]) begin
			wr(8'h00, {1'b1, codes[k], 4'h4});
			repeat (5) @(posedge i_clock);
			rdchk(8'h00, {1'b1, codes[k], 4'h0});
		end
		wr(8'h00, 8'h00);
		rdchk(8'h00, 8'h00);
		wr(8'h00, 8'h14);
		wr(8'h06, 8'h00);
		repeat (40) @(posedge i_clock);
		check(nwr[15:0] + ners[15:0] + nrd[15:0], s[15:0]);
		rdchk(8'h03, 8'ha0);
	endtask

	// ======================================================================
	// Main sequence
	initial begin
		i_clock = 1'b0;
		i_nrst = 1'b0;
		i_clk_en = 1'b1;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_fl_rdata = 16'h0000;
		miscompares = 0;
		num_checks = 0;
		nwr = 0;
		ners = 0;
		nrd = 0;
		repeat (16) @(posedge i_clock);
		i_nrst <= 1'b1;
		scen_reset;
		scen_locked;
		scen_read;
		scen_unlock;
		scen_fill;
		scen_erase;
		scen_program(1'b1);
		scen_erase;
		scen_program(1'b0);
		scen_reserved;
		test_done;
	end
endmodule // tb
